// ==== core/ctrl_pins_pkg.sv ====
// constants and types shared by both ends of the terminal control pins
package ctrl_pins_pkg;

  // ---------------------------------------------------------------
  // device register bus
  // ---------------------------------------------------------------
  localparam int             DATA_W          = 16;
  localparam int             ADDR_W          = 5;
  localparam logic [4:0]     REG_INT_MASK1   = 5'h00;
  localparam logic [4:0]     REG_CFG2        = 5'h02;
  localparam logic [4:0]     REG_START_RESET = 5'h03;
  localparam logic [4:0]     REG_TIME_TAG    = 5'h05;
  localparam logic [4:0]     REG_INT_STATUS1 = 5'h06;
  localparam logic [4:0]     REG_INT_MASK2   = 5'h1D;
  localparam logic [4:0]     REG_INT_STATUS2 = 5'h1E;
  localparam logic [15:0]    CFG2_RESET      = 16'h0000;
  localparam logic [15:0]    MASK_RESET      = 16'h0000;
  localparam logic [15:0]    DATA_ZERO       = 16'h0000;
  localparam int             CFG2_LEVEL_BIT  = 3;
  localparam int             CFG2_AUTOCLR_BIT = 4;
  localparam int             CFG2_TAGSEL_LO  = 7;
  localparam int             CFG2_TAGSEL_HI  = 9;
  localparam logic [2:0]     TAGSEL_EXTERNAL = 3'h7;
  localparam int             SR_INT_RESET_BIT = 2;

  // ---------------------------------------------------------------
  // upper address lines, index within addr_hi (A15..A12)
  // ---------------------------------------------------------------
  localparam int             ADDR_HI_W       = 4;
  localparam int             AH_CLKSEL_HI    = 3;
  localparam int             AH_CLKSEL_LO    = 2;
  localparam int             AH_FORCED_HI    = 1;
  localparam int             AH_BOOT         = 0;
  localparam logic [1:0]     CLKSEL_RESET    = 2'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int             CLK_MHZ_DEFAULT = 100;
  localparam int             PULSE_NS        = 500;
  localparam int             STROBE_CYCLES   = 2;
  localparam int             TAG_HALF_DEFAULT = 50;

  function automatic int pulse_cycles(input int clk_mhz);
    int c;
    c = (PULSE_NS * clk_mhz + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : pulse_cycles

  typedef enum logic [1:0] {
    IRQ_IDLE  = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_LEVEL = 2'b10
  } irq_state_type;

  // ---------------------------------------------------------------
  // host controller software port
  // ---------------------------------------------------------------
  localparam int             HOST_ADDR_W     = 6;
  localparam int             HOST_WIN_BIT    = 5;
  localparam logic [5:0]     HREG_PIN_CTRL   = 6'h00;
  localparam logic [5:0]     HREG_STATUS     = 6'h01;
  localparam logic [5:0]     HREG_MASK       = 6'h02;
  localparam int             PC_INH_A        = 0;
  localparam int             PC_INH_B        = 1;
  localparam int             PC_LOCKOUT      = 2;
  localparam int             PC_UPADDR_EN    = 3;
  localparam int             PC_MCLR         = 4;
  localparam int             PC_TAG_EN       = 5;
  localparam int             PC_CLKSEL_LO    = 8;
  localparam int             PC_CLKSEL_HI    = 9;
  localparam int             PC_BOOT_N       = 10;
  localparam logic [15:0]    PIN_CTRL_RESET  = 16'h0410;
  localparam int             HST_INT_EDGE    = 0;
  localparam int             HST_RT_RESET    = 1;
  localparam int             HST_W           = 2;

endpackage : ctrl_pins_pkg

// ==== core/ctrl_pins_if.sv ====
// pin-level connection between terminal device and host controller
`timescale 1ns/10ps
interface ctrl_pins_if;
  import ctrl_pins_pkg::*;

  logic              int_n;
  logic              rt_reset_cmd_strobe_n;
  logic              xmit_inhibit_chan_a;
  logic              xmit_inhibit_chan_b;
  logic              master_clear_n;
  logic              tag_clk;
  logic              controller_lockout;
  logic              upper_addr_enable;
  logic [ADDR_HI_W-1:0] addr_hi;
  logic              sleep_request_in;
  logic              self_test_enable_in;
  logic              reg_wr;
  logic              reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;

  modport device (
    output int_n, rt_reset_cmd_strobe_n, reg_rdata,
    input  xmit_inhibit_chan_a, xmit_inhibit_chan_b, master_clear_n, tag_clk,
    input  controller_lockout, upper_addr_enable, addr_hi,
    input  sleep_request_in, self_test_enable_in,
    input  reg_wr, reg_rd, reg_addr, reg_wdata
  );

  modport host (
    input  int_n, rt_reset_cmd_strobe_n, reg_rdata,
    output xmit_inhibit_chan_a, xmit_inhibit_chan_b, master_clear_n, tag_clk,
    output controller_lockout, upper_addr_enable, addr_hi,
    output sleep_request_in, self_test_enable_in,
    output reg_wr, reg_rd, reg_addr, reg_wdata
  );
endinterface : ctrl_pins_if

// ==== core/pin_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : pin_sync

// ==== core/term_ctrl_device.sv ====
// terminal device end: interrupt output, reset strobe, control pin decode
// What this block and the host do
// [R1] reset command in RT mode gives two-cycle low strobe
// [R2] pulse mode: ~500 ns low interrupt pulse
// [R3] level mode: interrupt held low until cleared
// [R4] interrupt reset bit write releases level
// [R5] auto-clear: status read clears request
// [R6] both pending registers must be read
// [R7] status write-back clears returned ones
// [R8] inhibit high shuts that transmitter down
// [R9] master clear low resets the device
// [R10] cfg bits 7-9 set: external tag clock
// [R11] lockout high forbids bus controller mode
// [R12] upper address lines become clock select, boot
// [R13] host holds A13 high then
// [R14] upper address lines ignored when enabled
// [R15] sleep and self-test inputs ignored
// [R16] pulse width counted in clock cycles
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module term_ctrl_device
  import ctrl_pins_pkg::*;
#(
  parameter int CLK_MHZ = CLK_MHZ_DEFAULT
) (
  input  wire logic                        REF_CLK_IN,
  input  wire logic                        RESET_IN,
  ctrl_pins_if.device                      PINS,
  input  wire logic                        RT_MODE_IN,
  input  wire logic                        RESET_CMD_IN,
  input  wire logic [ctrl_pins_pkg::DATA_W-1:0] EVENT1_IN,
  input  wire logic [ctrl_pins_pkg::DATA_W-1:0] EVENT2_IN,
  output logic                             DEVICE_RESET_OUT,
  output logic                             TX_SHUTDOWN_A_OUT,
  output logic                             TX_SHUTDOWN_B_OUT,
  output logic                             BC_ENABLE_OUT,
  output logic [1:0]                       CLK_SEL_OUT,
  output logic                             TERMINAL_BOOT_N_OUT,
  output logic [ctrl_pins_pkg::DATA_W-1:0] TIME_TAG_OUT
);
  import ctrl_pins_pkg::*;

  localparam int PULSE_CYC = pulse_cycles(CLK_MHZ);
  localparam int CNT_W     = $clog2(PULSE_CYC + 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = '0;
  localparam logic [1:0] STROBE_LOAD = 2'(STROBE_CYCLES - 1);

  generate
    if (CLK_MHZ < 1 || CLK_MHZ > 1000) begin : g_bad_clk
      $error("CLK_MHZ out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 5 + ADDR_HI_W + 1;
  logic [SYNC_W-1:0] sync_q;
  logic              inh_a_s, inh_b_s, mclr_n_s, tag_s, lock_s, upen_s;
  logic [ADDR_HI_W-1:0] ahi_s;

  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_in (REF_CLK_IN),
    .rst_in (RESET_IN),
    .d_in   ({PINS.xmit_inhibit_chan_a, PINS.xmit_inhibit_chan_b, PINS.master_clear_n,
              PINS.tag_clk, PINS.controller_lockout, PINS.addr_hi,
              PINS.upper_addr_enable}),
    .q_out  (sync_q)
  );
  assign {inh_a_s, inh_b_s, mclr_n_s, tag_s, lock_s, ahi_s, upen_s} = sync_q;

  // sleep and self-test pins unused  // [R15]

  logic dev_rst;
  assign dev_rst = RESET_IN | ~mclr_n_s;  // [R9]

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] cfg2, mask1, mask2, status1, status2, time_tag;
  logic [DATA_W-1:0] next_status1, next_status2;
  logic              wr_sr, wr_cfg, wr_m1, wr_m2, wr_s1, wr_s2, wr_tt;
  logic              rd_s1, rd_s2, auto_clr, level_mode;
  logic [DATA_W-1:0] clr1, clr2;

  assign level_mode = cfg2[CFG2_LEVEL_BIT];
  assign auto_clr   = cfg2[CFG2_AUTOCLR_BIT];

  always_comb begin
    wr_sr = 1'b0; wr_cfg = 1'b0; wr_m1 = 1'b0; wr_m2 = 1'b0;
    wr_s1 = 1'b0; wr_s2 = 1'b0; wr_tt = 1'b0; rd_s1 = 1'b0; rd_s2 = 1'b0;
    if (PINS.reg_addr == REG_START_RESET) begin
      wr_sr = PINS.reg_wr;
    end else if (PINS.reg_addr == REG_CFG2) begin
      wr_cfg = PINS.reg_wr;
    end else if (PINS.reg_addr == REG_INT_MASK1) begin
      wr_m1 = PINS.reg_wr;
    end else if (PINS.reg_addr == REG_INT_MASK2) begin
      wr_m2 = PINS.reg_wr;
    end else if (PINS.reg_addr == REG_INT_STATUS1) begin
      wr_s1 = PINS.reg_wr;
      rd_s1 = PINS.reg_rd;
    end else if (PINS.reg_addr == REG_INT_STATUS2) begin
      wr_s2 = PINS.reg_wr;
      rd_s2 = PINS.reg_rd;
    end else if (PINS.reg_addr == REG_TIME_TAG) begin
      wr_tt = PINS.reg_wr;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (dev_rst) begin
      cfg2  <= CFG2_RESET;
      mask1 <= MASK_RESET;
      mask2 <= MASK_RESET;
    end else begin
      if (wr_cfg) cfg2 <= PINS.reg_wdata;
      if (wr_m1) mask1 <= PINS.reg_wdata;
      if (wr_m2) mask2 <= PINS.reg_wdata;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (dev_rst) begin
      PINS.reg_rdata <= DATA_ZERO;
    end else if (PINS.reg_rd) begin
      if (PINS.reg_addr == REG_CFG2) begin
        PINS.reg_rdata <= cfg2;
      end else if (PINS.reg_addr == REG_INT_MASK1) begin
        PINS.reg_rdata <= mask1;
      end else if (PINS.reg_addr == REG_INT_MASK2) begin
        PINS.reg_rdata <= mask2;
      end else if (PINS.reg_addr == REG_INT_STATUS1) begin
        PINS.reg_rdata <= status1;
      end else if (PINS.reg_addr == REG_INT_STATUS2) begin
        PINS.reg_rdata <= status2;
      end else if (PINS.reg_addr == REG_TIME_TAG) begin
        PINS.reg_rdata <= time_tag;
      end else begin
        PINS.reg_rdata <= DATA_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status; set wins over clear
  // ---------------------------------------------------------------
  always_comb begin
    clr1 = DATA_ZERO;
    clr2 = DATA_ZERO;
    if (rd_s1 && auto_clr) clr1 = status1;  // [R5]
    if (rd_s2 && auto_clr) clr2 = status2;  // [R5]
    if (wr_s1) clr1 = PINS.reg_wdata;  // [R7]
    if (wr_s2) clr2 = PINS.reg_wdata;  // [R7]
    next_status1 = (status1 & ~clr1) | EVENT1_IN;
    next_status2 = (status2 & ~clr2) | EVENT2_IN;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (dev_rst) begin
      status1 <= DATA_ZERO;
      status2 <= DATA_ZERO;
    end else begin
      status1 <= next_status1;
      status2 <= next_status2;
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  irq_state_type     irq_state, next_irq_state;
  logic [CNT_W-1:0]  pulse_cnt;
  logic              any_new, still_pending, int_reset, release_level;

  assign any_new       = |((EVENT1_IN & ~status1 & mask1) | (EVENT2_IN & ~status2 & mask2));
  // held while any unmasked bit remains
  assign still_pending = |((next_status1 & mask1) | (next_status2 & mask2));  // [R6]
  assign int_reset     = wr_sr & PINS.reg_wdata[SR_INT_RESET_BIT];
  assign release_level = int_reset | ((rd_s1 | rd_s2 | wr_s1 | wr_s2) & ~still_pending);  // [R4]

  always_comb begin
    next_irq_state = irq_state;
    case (irq_state)
      IRQ_IDLE: begin
        if (any_new) next_irq_state = level_mode ? IRQ_LEVEL : IRQ_PULSE;  // [R2] [R3]
      end
      IRQ_PULSE: begin
        if (pulse_cnt == CNT_ZERO && !any_new) next_irq_state = IRQ_IDLE;  // [R16]
      end
      IRQ_LEVEL: begin
        if (release_level && !any_new) next_irq_state = IRQ_IDLE;  // [R3]
      end
      default: next_irq_state = IRQ_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (dev_rst) begin
      irq_state  <= IRQ_IDLE;
      pulse_cnt  <= CNT_ZERO;
      PINS.int_n <= 1'b1;
    end else begin
      irq_state  <= next_irq_state;
      PINS.int_n <= (next_irq_state == IRQ_IDLE);
      if (any_new && !level_mode) begin
        pulse_cnt <= PULSE_LOAD;  // [R16]
      end else if (pulse_cnt != CNT_ZERO) begin
        pulse_cnt <= pulse_cnt - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // reset-command strobe
  // ---------------------------------------------------------------
  logic [1:0] strobe_cnt;

  always_ff @(posedge REF_CLK_IN) begin
    if (dev_rst) begin
      strobe_cnt                 <= 2'h0;
      PINS.rt_reset_cmd_strobe_n <= 1'b1;
    end else if (RESET_CMD_IN && RT_MODE_IN) begin
      strobe_cnt                 <= STROBE_LOAD;  // [R1]
      PINS.rt_reset_cmd_strobe_n <= 1'b0;
    end else if (strobe_cnt != 2'h0) begin
      strobe_cnt <= strobe_cnt - 1'b1;
    end else begin
      PINS.rt_reset_cmd_strobe_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // time tag, external source only
  // ---------------------------------------------------------------
  logic tag_prev;

  always_ff @(posedge REF_CLK_IN) begin
    if (dev_rst) begin
      tag_prev <= 1'b0;
      time_tag <= DATA_ZERO;
    end else begin
      tag_prev <= tag_s;
      if (wr_tt) begin
        time_tag <= PINS.reg_wdata;
      end else if (cfg2[CFG2_TAGSEL_HI:CFG2_TAGSEL_LO] == TAGSEL_EXTERNAL
                   && tag_s && !tag_prev) begin
        time_tag <= time_tag + 1'b1;  // [R10]
      end
    end
  end

  // ---------------------------------------------------------------
  // control pin decode
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (dev_rst) begin
      TX_SHUTDOWN_A_OUT   <= 1'b0;
      TX_SHUTDOWN_B_OUT   <= 1'b0;
      BC_ENABLE_OUT       <= 1'b0;
      CLK_SEL_OUT         <= CLKSEL_RESET;
      TERMINAL_BOOT_N_OUT <= 1'b1;
    end else begin
      TX_SHUTDOWN_A_OUT <= inh_a_s;  // [R8]
      TX_SHUTDOWN_B_OUT <= inh_b_s;  // [R8]
      BC_ENABLE_OUT     <= ~lock_s;  // [R11]
      if (!upen_s) begin
        CLK_SEL_OUT         <= {ahi_s[AH_CLKSEL_HI], ahi_s[AH_CLKSEL_LO]};  // [R12]
        TERMINAL_BOOT_N_OUT <= ahi_s[AH_BOOT];  // [R12]
      end else begin
        CLK_SEL_OUT         <= CLKSEL_RESET;  // [R14]
        TERMINAL_BOOT_N_OUT <= 1'b1;  // [R14]
      end
    end
  end

  assign DEVICE_RESET_OUT = dev_rst;
  assign TIME_TAG_OUT     = time_tag;

endmodule : term_ctrl_device

// ==== core/term_ctrl_host.sv ====
// host controller end: drives control pins, forwards register access
`timescale 1ns/10ps
module term_ctrl_host
  import ctrl_pins_pkg::*;
#(
  parameter int TAG_HALF = TAG_HALF_DEFAULT
) (
  input  wire logic                             REF_CLK_IN,
  input  wire logic                             RESET_IN,
  ctrl_pins_if.host                             PINS,
  input  wire logic [ctrl_pins_pkg::HOST_ADDR_W-1:0] ADDR_IN,
  input  wire logic [ctrl_pins_pkg::DATA_W-1:0] WDATA_IN,
  input  wire logic                             WR_IN,
  input  wire logic                             RD_IN,
  output logic      [ctrl_pins_pkg::DATA_W-1:0] RDATA_OUT,
  output logic                                  IRQ_OUT
);
  import ctrl_pins_pkg::*;

  localparam int DIV_W = $clog2(TAG_HALF + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TAG_HALF - 1);

  generate
    if (TAG_HALF < 1) begin : g_bad_div
      $error("TAG_HALF must be at least one");
    end
  endgenerate

  // ---------------------------------------------------------------
  // own registers and device window
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] pin_ctrl, host_rdata;
  logic [HST_W-1:0]  hstat, hmask, hev;
  logic              win, rd_win;

  assign win            = ADDR_IN[HOST_WIN_BIT];
  assign PINS.reg_wr    = WR_IN & win;
  assign PINS.reg_rd    = RD_IN & win;
  assign PINS.reg_addr  = ADDR_IN[ADDR_W-1:0];
  assign PINS.reg_wdata = WDATA_IN;
  assign RDATA_OUT      = rd_win ? PINS.reg_rdata : host_rdata;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      pin_ctrl <= PIN_CTRL_RESET;
      hmask    <= '0;
    end else if (WR_IN && !win) begin
      if (ADDR_IN == HREG_PIN_CTRL) begin
        pin_ctrl <= WDATA_IN;
      end else if (ADDR_IN == HREG_MASK) begin
        hmask <= WDATA_IN[HST_W-1:0];
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      rd_win     <= 1'b0;
      host_rdata <= DATA_ZERO;
    end else begin
      rd_win <= RD_IN & win;
      if (RD_IN && !win) begin
        if (ADDR_IN == HREG_PIN_CTRL) begin
          host_rdata <= pin_ctrl;
        end else if (ADDR_IN == HREG_STATUS) begin
          host_rdata <= {{(DATA_W-HST_W){1'b0}}, hstat};
        end else if (ADDR_IN == HREG_MASK) begin
          host_rdata <= {{(DATA_W-HST_W){1'b0}}, hmask};
        end else begin
          host_rdata <= DATA_ZERO;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // device pin events; read clears, set wins
  // ---------------------------------------------------------------
  logic [1:0] in_s, in_prev;

  pin_sync #(.WIDTH(2)) u_sync (
    .clk_in (REF_CLK_IN),
    .rst_in (RESET_IN),
    .d_in   ({PINS.int_n, PINS.rt_reset_cmd_strobe_n}),
    .q_out  (in_s)
  );

  assign hev[HST_INT_EDGE] = in_prev[1] & ~in_s[1];
  assign hev[HST_RT_RESET] = in_prev[0] & ~in_s[0];

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      in_prev <= 2'h0;
      hstat   <= '0;
    end else begin
      in_prev <= in_s;
      if (RD_IN && !win && ADDR_IN == HREG_STATUS) begin
        hstat <= hev;
      end else begin
        hstat <= hstat | hev;
      end
    end
  end

  assign IRQ_OUT = |(hstat & hmask);

  // ---------------------------------------------------------------
  // tag clock divider and pin drive
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;
  logic             tag_clk_q;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN || !pin_ctrl[PC_TAG_EN]) begin
      div_cnt   <= '0;
      tag_clk_q <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt   <= '0;
      tag_clk_q <= ~tag_clk_q;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign PINS.tag_clk             = tag_clk_q;
  assign PINS.xmit_inhibit_chan_a = pin_ctrl[PC_INH_A];
  assign PINS.xmit_inhibit_chan_b = pin_ctrl[PC_INH_B];
  assign PINS.controller_lockout  = pin_ctrl[PC_LOCKOUT];
  assign PINS.upper_addr_enable   = pin_ctrl[PC_UPADDR_EN];
  // held low from reset until software releases it
  assign PINS.master_clear_n      = ~pin_ctrl[PC_MCLR];  // [R9]
  // A13 high keeps clock-select legal  // [R13]
  assign PINS.addr_hi = {pin_ctrl[PC_CLKSEL_HI], pin_ctrl[PC_CLKSEL_LO], 1'b1,
                         pin_ctrl[PC_BOOT_N]};
  assign PINS.sleep_request_in    = 1'b0;
  assign PINS.self_test_enable_in = 1'b0;

endmodule : term_ctrl_host

// ==== dv/ctrl_pins_assertions.sv ====
// concurrent checks on the control pins
`timescale 1ns/10ps
module ctrl_pins_assertions
  import ctrl_pins_pkg::*;
#(
  parameter int CLK_MHZ = CLK_MHZ_DEFAULT
) (
  input  wire logic                             REF_CLK_IN,
  input  wire logic                             RESET_IN,
  input  wire logic                             int_n,
  input  wire logic                             rt_reset_cmd_strobe_n,
  input  wire logic                             master_clear_n,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  input  wire logic [ctrl_pins_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ctrl_pins_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [ctrl_pins_pkg::DATA_W-1:0] reg_rdata
);
  localparam int PW = (PULSE_NS * CLK_MHZ + 999) / 1000;
  logic level_mode;
  int   low_cnt;
  wire  strb_n = rt_reset_cmd_strobe_n;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // ------------------
  // shadow of the level mode bit
  // ------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN || !master_clear_n) begin
      level_mode <= 1'b0;
    end else if (reg_wr && reg_addr == REG_CFG2) begin
      level_mode <= reg_wdata[CFG2_LEVEL_BIT];
    end
  end
  always_ff @(posedge REF_CLK_IN) begin
    low_cnt <= (RESET_IN || int_n) ? 0 : low_cnt + 1;
  end
  sequence two_low;
    !strb_n ##1 !strb_n;
  endsequence
  a_strobe_two_low: assert property ($fell(strb_n) |-> two_low ##1 strb_n)
    else $error("strobe width");
  a_pulse_width: assert property (!level_mode && $rose(int_n) |-> low_cnt == PW)
    else $error("pulse width");
  a_pulse_bound: assert property (!level_mode && !int_n |-> low_cnt < PW)
    else $error("pulse too long");
  a_level_held: assert property (level_mode && !int_n && !reg_wr && !reg_rd |=> !int_n)
    else $error("level dropped");
  a_level_release_cause: assert property (
    level_mode && $rose(int_n) |-> $past(reg_wr) || $past(reg_rd))
    else $error("level released unasked");
  a_int_reset_bit: assert property (
    level_mode && reg_wr && reg_addr == REG_START_RESET && reg_wdata[SR_INT_RESET_BIT]
    |=> int_n) else $error("int reset ignored");
  a_start_reset_reads_zero: assert property (
    reg_rd && reg_addr == REG_START_RESET |=> reg_rdata == DATA_ZERO)
    else $error("start reset read");
  a_clear_quiet: assert property (!master_clear_n [*3] |=> int_n && strb_n)
    else $error("active in master clear");
endmodule : ctrl_pins_assertions

// ==== dv/interrupt_and_control_pins_test.sv ====
// self-checking bench for both terminal control ends
`timescale 1ns/10ps
module interrupt_and_control_pins_test;
  import ctrl_pins_pkg::*;
  logic        clk, rst, wr_s, rd_s, rt_mode, cmd, dev_rst, sh_a, sh_b, bc_en, boot_n, irq;
  logic [5:0]  addr;
  logic [1:0]  csel;
  logic [15:0] wdata, rdata, ev1, ev2, tag, pc, d, e;
  logic [31:0] seed = 32'h0000000D;
  int          error_cnt = 0, checks_done = 0, cycles = 0;
  integer      ni, ns;
  ctrl_pins_if pins ();
  term_ctrl_device u_term_ctrl_device (.REF_CLK_IN(clk), .RESET_IN(rst), .PINS(pins),
    .RT_MODE_IN(rt_mode), .RESET_CMD_IN(cmd), .EVENT1_IN(ev1), .EVENT2_IN(ev2),
    .DEVICE_RESET_OUT(dev_rst), .TX_SHUTDOWN_A_OUT(sh_a), .TX_SHUTDOWN_B_OUT(sh_b),
    .BC_ENABLE_OUT(bc_en), .CLK_SEL_OUT(csel), .TERMINAL_BOOT_N_OUT(boot_n),
    .TIME_TAG_OUT(tag));
  term_ctrl_host #(.TAG_HALF(2)) u_term_ctrl_host (.REF_CLK_IN(clk), .RESET_IN(rst),
    .PINS(pins), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
    .RDATA_OUT(rdata), .IRQ_OUT(irq));
  ctrl_pins_assertions #(.CLK_MHZ(CLK_MHZ_DEFAULT)) u_ctrl_pins_assertions (
    .REF_CLK_IN(clk), .RESET_IN(rst), .int_n(pins.int_n),
    .rt_reset_cmd_strobe_n(pins.rt_reset_cmd_strobe_n), .master_clear_n(pins.master_clear_n),
    .reg_wr(pins.reg_wr), .reg_rd(pins.reg_rd), .reg_addr(pins.reg_addr),
    .reg_wdata(pins.reg_wdata), .reg_rdata(pins.reg_rdata));
  // ------------------
  // helpers
  // ------------------
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  // expected {boot_n, csel, bc_en, sh_b, sh_a}
  function automatic logic [15:0] pin_exp(input logic [15:0] p);
    return {10'h000, p[3] | p[10], p[3] ? 2'h0 : p[9:8], ~p[2], p[1], p[0]};
  endfunction : pin_exp
  task automatic check(input string name, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    {addr, wdata, wr_s} <= {a, v, 1'b1};
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk);
    {addr, rd_s} <= {a, 1'b1};
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic pulse(input logic [15:0] a, b, input logic c);
    @(posedge clk);
    {ev1, ev2, cmd} <= {a, b, c};
    @(posedge clk);
    {ev1, ev2, cmd} <= '0;
  endtask : pulse
  // low cycles of int_n and strobe
  task automatic lows(input int win);
    ni = 0;
    ns = 0;
    repeat (win) begin
      #1 ni += !pins.int_n;
      ns += !pins.rt_reset_cmd_strobe_n;
      @(posedge clk);
    end
  endtask : lows
  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard; run takes under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    {rst, wr_s, rd_s, rt_mode, cmd, addr, wdata, ev1, ev2} = {1'b1, 58'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wr(6'h00, 16'h0400);
    repeat (5) @(posedge clk);
    #1 check("device_reset", dev_rst, 1'b0);
    wr(6'h02, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      pc = (i == 0) ? 16'h0708 : rnd() & 16'h070F;
      wr(6'h00, pc);
      repeat (5) @(posedge clk);
      #1 check("pins", {10'h000, boot_n, csel, bc_en, sh_b, sh_a}, pin_exp(pc));
      check("addr13", pins.addr_hi[AH_FORCED_HI], 1'b1);
    end
    wr(6'h00, 16'h0400);
    wr(6'h20, 16'hFFFF);
    wr(6'h3D, 16'hFFFF);
    wr(6'h22, 16'h0000);
    e = rnd() | 16'h0001;
    pulse(e, 16'h0000, 1'b0);
    lows(70);
    check("pulse_len", ni, PULSE_NS * CLK_MHZ_DEFAULT / 1000);
    check("irq_raised", irq, 1'b1);
    rd(6'h01, d);
    check("host_status", d, 16'h0001);
    rd(6'h26, d);
    check("status1", d, e);
    wr(6'h26, d);
    rd(6'h26, d);
    check("status1_wb", d, 16'h0000);
    wr(6'h22, 16'h0008);
    pulse(16'h0002, 16'h0000, 1'b0);
    lows(20);
    check("level_low", ni, 20);
    wr(6'h23, 16'h0004);
    #1 check("int_reset", pins.int_n, 1'b1);
    wr(6'h26, 16'h0002);
    wr(6'h22, 16'h0018);
    pulse(16'h0010, 16'h0020, 1'b0);
    rd(6'h26, d);
    check("auto_s1", d, 16'h0010);
    check("one_read", pins.int_n, 1'b0);
    rd(6'h3E, d);
    check("auto_s2", d, 16'h0020);
    check("both_read", pins.int_n, 1'b1);
    rd(6'h26, d);
    check("auto_clr", d, 16'h0000);
    rd(6'h01, d);
    @(posedge clk) rt_mode <= 1'b1;
    pulse(16'h0000, 16'h0000, 1'b1);
    lows(8);
    check("strobe_len", ns, 2);
    check("irq_masked", irq, 1'b0);
    wr(6'h02, 16'h0003);
    repeat (2) @(posedge clk);
    #1 check("irq_unmasked", irq, 1'b1);
    rd(6'h01, d);
    check("host_strobe", d, 16'h0002);
    repeat (2) @(posedge clk);
    #1 check("irq_cleared", irq, 1'b0);
    @(posedge clk) rt_mode <= 1'b0;
    pulse(16'h0000, 16'h0000, 1'b1);
    lows(8);
    check("strobe_not_rt", ns, 0);
    rd(6'h07, d);
    check("host_unmapped", d, 16'h0000);
    rd(6'h2F, d);
    check("dev_unmapped", d, 16'h0000);
    rd(6'h23, d);
    check("start_reset_rd", d, 16'h0000);
    wr(6'h22, 16'h0180);
    wr(6'h00, 16'h0420);
    repeat (40) @(posedge clk);
    #1 check("tag_held", tag, 16'h0000);
    wr(6'h22, 16'h0380);
    repeat (40) @(posedge clk);
    #1 check("tag_runs", tag >= 16'h0008 && tag <= 16'h000B, 1'b1);
    stop_test();
  end
endmodule : interrupt_and_control_pins_test
